// ===== core/rad_debounce.sv
// Two-flop synchroniser and stability filter for one switch or alarm input.
// Assumes a single system clock; output changes after the input holds steady.
`timescale 1ns/1ps
`default_nettype none
module rad_debounce #(
   parameter int unsigned STABLE_CYCLES = rad_pkg::DEBOUNCE_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_raw,
   output logic o_clean
);
   localparam int CW = $clog2(STABLE_CYCLES + 1);
   initial
   begin
      if (STABLE_CYCLES < 1) $error("rad_debounce: STABLE_CYCLES must be at least 1");
   end
   logic meta;
   logic sync;
   logic [CW-1:0] cnt;
   wire differs = sync != o_clean;
   wire settled = cnt == CW'(STABLE_CYCLES - 1);

   // Synchroniser; first flop feeds only the second
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
      end
      else
      begin
         meta <= i_raw;
         sync <= meta;
      end
   end

   // Accept a new level only after it stays put
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cnt <= '0;
         o_clean <= 1'b0;
      end
      else if (!differs)
         cnt <= '0;
      else if (settled)
      begin
         cnt <= '0;
         o_clean <= sync;
      end
      else
         cnt <= cnt + CW'(1);
   end
endmodule : rad_debounce
`default_nettype wire

// ===== core/rad_pkg.sv
// Constants, types and timing figures for the releasing-zone abort delay timer.
// Assumes a single 125 MHz system clock; all countdowns run in whole seconds.
package rad_pkg;
   // Clock rate and the derived one-second tick
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_SEC = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;
   // Second counter width
   localparam int SEC_W = 8;
   // Programmed delay limits, in seconds
   localparam logic [SEC_W-1:0] DELAY_MAX_S = 8'h3C;
   // Fixed countdowns, in seconds
   localparam logic [SEC_W-1:0] RELEASE_WAIT_S = 8'h0A;
   localparam logic [SEC_W-1:0] ADDON_S = 8'h5A;
   localparam logic [SEC_W-1:0] CAP_S = 8'h78;
   // Input debounce time in milliseconds, and in cycles
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
   // Abort behaviour codes
   typedef enum logic [1:0] {
      RAD_STANDARD_ABORT_MODE = 2'h0,
      RAD_CROSS_ZONE_HOLD_ABORT = 2'h1,
      RAD_EXTENDED_RESTART_ABORT = 2'h2,
      RAD_SUSPEND_RESTORE_ABORT = 2'h3
   } rad_abort_t;
   // Cross-zone qualification codes
   typedef enum logic [1:0] {
      RAD_CROSS_NONE = 2'h0,
      RAD_CROSS_TWO_DETECTOR = 2'h1
   } rad_cross_t;
   // Zone sequencer states
   typedef enum logic [2:0] {
      RAD_IDLE = 3'h0,
      RAD_DELAY = 3'h1,
      RAD_HELD = 3'h2,
      RAD_WAIT = 3'h3,
      RAD_ADDON = 3'h4,
      RAD_RELEASED = 3'h5,
      RAD_ARMED = 3'h6
   } rad_state_t;
endpackage : rad_pkg

// ===== core/rad_tick.sv
// One-second tick generator from the system clock.
// Assumes a free-running system clock; tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module rad_tick #(
   parameter int unsigned TICK_CYCLES = rad_pkg::TICK_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   output logic o_tick
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   initial
   begin
      if (TICK_CYCLES < 2) $error("rad_tick: TICK_CYCLES must be at least 2");
   end
   logic [CW-1:0] cnt;
   wire wrap = cnt == CW'(TICK_CYCLES - 1);

   // Divider, pulse on wrap
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cnt <= '0;
         o_tick <= 1'b0;
      end
      else
      begin
         cnt <= wrap ? '0 : cnt + CW'(1);
         o_tick <= wrap;
      end
   end
endmodule : rad_tick
`default_nettype wire

// ===== core/rad_zone_timer.sv
// Abort and release delay sequencer for one releasing zone.
// Assumes static configuration inputs, raw switch/alarm inputs, one clock.
// Function
// - Cross-zone hold: abort held blocks activation when second alarm arrives.
// - Cross-zone hold: release after held second alarm starts 10 s countdown.
// - Cross-zone hold: release without second alarm waits for cross-zone qualification.
// - Cross-zone hold: abort pressed after second alarm has no effect.
// - Extended restart: holding abort halts the delay countdown.
// - Extended restart: abort release reloads full programmed delay.
// - Extended restart: 90 s add-on follows delay, then activate.
// - Extended restart: activate no later than 120 s after abort release.
// - Suspend-restore: alarm starts delay; held abort suspends it.
// - Suspend-restore: release reloads delay, counts, activates on expiry.
// - Abort type settable by code entry or next/previous stepping.
// - Standard: release counts 10 s then activates; late abort ignored.
// - Delay holds 0 to 60 seconds, zero meaning no delay.
// - Two-detector cross-zone qualifies only with two or more alarms.
`timescale 1ns/1ps
`default_nettype none
module rad_zone_timer #(
   parameter int unsigned N_DET = 4,
   parameter int unsigned TICK_CYCLES = rad_pkg::TICK_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = rad_pkg::DEBOUNCE_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [N_DET-1:0] i_alarm,
   input wire logic i_abort_sw,
   input wire logic [7:0] i_delay_s,
   input wire logic [1:0] i_cross,
   input wire logic i_type_load,
   input wire logic [1:0] i_type_code,
   input wire logic i_type_next,
   input wire logic i_type_prev,
   output logic [1:0] o_abort_type,
   output logic [2:0] o_state,
   output logic [7:0] o_seconds_left,
   output logic o_release
);
   initial
   begin
      if (N_DET < 2) $error("rad_zone_timer: N_DET must be at least 2");
   end

   logic [N_DET-1:0] alarm;
   logic abort_held;
   logic tick;

   genvar g;
   generate
      for (g = 0; g < N_DET; g++)
      begin : g_det
         rad_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db (
            .i_sys_clk(i_sys_clk),
            .i_rst_b(i_rst_b),
            .i_raw(i_alarm[g]),
            .o_clean(alarm[g])
         );
      end
   endgenerate
   rad_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_abort (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_raw(i_abort_sw),
      .o_clean(abort_held)
   );
   rad_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .o_tick(tick)
   );

   // Alarm count and qualification
   logic [$clog2(N_DET+1)-1:0] n_alarm;
   always_comb
   begin
      n_alarm = '0;
      for (int k = 0; k < N_DET; k++)
         n_alarm = n_alarm + {{($clog2(N_DET+1)-1){1'b0}}, alarm[k]};
   end
   wire any_alarm = |alarm;
   localparam int NA_W = $clog2(N_DET+1);
   wire two_alarm = n_alarm >= NA_W'(2);
   wire cross_on = i_cross == rad_pkg::RAD_CROSS_TWO_DETECTOR;
   wire qualified = cross_on ? two_alarm : any_alarm;
   wire [7:0] delay_val = (i_delay_s > rad_pkg::DELAY_MAX_S) ? rad_pkg::DELAY_MAX_S : i_delay_s;

   // abort type store: direct code or stepping
   logic [1:0] abort_type;
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         abort_type <= rad_pkg::RAD_STANDARD_ABORT_MODE;
      else if (i_type_load)
         abort_type <= i_type_code;
      else if (i_type_next)
         abort_type <= abort_type + 2'h1;
      else if (i_type_prev)
         abort_type <= abort_type - 2'h1;
   end
   assign o_abort_type = abort_type;

   // Mode decode
   wire m_std = abort_type == rad_pkg::RAD_STANDARD_ABORT_MODE;
   wire m_xzh = abort_type == rad_pkg::RAD_CROSS_ZONE_HOLD_ABORT;
   wire m_ext = abort_type == rad_pkg::RAD_EXTENDED_RESTART_ABORT;
   wire m_sus = abort_type == rad_pkg::RAD_SUSPEND_RESTORE_ABORT;

   rad_pkg::rad_state_t state;
   rad_pkg::rad_state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] cap;
   logic [7:0] next_cap;
   logic second_seen;
   logic next_second_seen;
   wire cnt_zero = cnt == 8'h00;
   wire cap_zero = cap == 8'h00;

   // Zone sequencer next state
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_cap = cap;
      next_second_seen = second_seen;
      case (state)
         rad_pkg::RAD_IDLE:
         begin
            // Cross-zone hold mode arms on first alarm
            if (m_xzh && cross_on && any_alarm && !qualified)
               next_state = rad_pkg::RAD_ARMED;
            else if (qualified)
            begin
               next_state = rad_pkg::RAD_DELAY;
               next_cnt = delay_val;
            end
         end
         rad_pkg::RAD_ARMED:
         begin
            if (abort_held)
            begin
               next_state = rad_pkg::RAD_HELD;
               next_second_seen = 1'b0;
            end
            // second alarm without hold goes straight on
            else if (qualified)
            begin
               next_state = rad_pkg::RAD_DELAY;
               next_cnt = delay_val;
            end
            else if (!any_alarm)
               next_state = rad_pkg::RAD_IDLE;
         end
         rad_pkg::RAD_DELAY:
         begin
            // standard, extended restart and suspend-restore: hold takes over
            if (abort_held && !m_xzh)
            begin
               next_state = rad_pkg::RAD_HELD;
               next_second_seen = 1'b0;
            end
            else if (cnt_zero)
            begin
               if (m_ext)
               begin
                  next_state = rad_pkg::RAD_ADDON;
                  next_cnt = rad_pkg::ADDON_S;
               end
               else
                  next_state = rad_pkg::RAD_RELEASED;
            end
            else if (tick)
               next_cnt = cnt - 8'h01;
         end
         rad_pkg::RAD_HELD:
         begin
            // held abort blocks and notes a second alarm
            if (qualified)
               next_second_seen = 1'b1;
            // other modes freeze the count while held
            // standard: delay keeps counting while held
            if (m_std && !cnt_zero && tick)
               next_cnt = cnt - 8'h01;
            if (!abort_held)
            begin
               if (m_xzh)
               begin
                  // ten-second wait after held second alarm
                  if (second_seen || qualified)
                  begin
                     next_state = rad_pkg::RAD_WAIT;
                     next_cnt = rad_pkg::RELEASE_WAIT_S;
                  end
                  else
                     next_state = rad_pkg::RAD_ARMED;
               end
               else if (m_std)
               begin
                  next_state = rad_pkg::RAD_WAIT;
                  next_cnt = rad_pkg::RELEASE_WAIT_S;
               end
               else
               begin
                  next_state = rad_pkg::RAD_DELAY;
                  next_cnt = delay_val;
                  next_cap = rad_pkg::CAP_S;
               end
            end
         end
         rad_pkg::RAD_WAIT:
         begin
            if (cnt_zero)
               next_state = rad_pkg::RAD_RELEASED;
            else if (tick)
               next_cnt = cnt - 8'h01;
         end
         rad_pkg::RAD_ADDON:
         begin
            if (cnt_zero)
               next_state = rad_pkg::RAD_RELEASED;
            else if (tick)
               next_cnt = cnt - 8'h01;
         end
         rad_pkg::RAD_RELEASED:
            next_state = rad_pkg::RAD_RELEASED;
         default:
            next_state = rad_pkg::RAD_IDLE;
      endcase
      // cap forces release in extended mode
      if (m_ext && (state == rad_pkg::RAD_DELAY || state == rad_pkg::RAD_ADDON))
      begin
         if (cap_zero)
            next_state = rad_pkg::RAD_RELEASED;
         else if (tick)
            next_cap = cap - 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state <= rad_pkg::RAD_IDLE;
         cnt <= 8'h00;
         cap <= 8'hFF;
         second_seen <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         cap <= next_cap;
         second_seen <= next_second_seen;
      end
   end

   // Release output and status from flops
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_release <= 1'b0;
         o_state <= 3'h0;
         o_seconds_left <= 8'h00;
      end
      else
      begin
         o_release <= next_state == rad_pkg::RAD_RELEASED;
         o_state <= next_state;
         o_seconds_left <= next_cnt;
      end
   end

   // Assertions
   sequence s_held_second;
      state == rad_pkg::RAD_HELD && qualified && m_xzh;
   endsequence
   hold_blocks_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (s_held_second and abort_held) |=> !o_release)
      else $error("release while abort held");
   xz_wait_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (s_held_second and !abort_held)
      |=> state == rad_pkg::RAD_WAIT && cnt == rad_pkg::RELEASE_WAIT_S)
      else $error("ten second wait not started");
   xz_rearm_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      state == rad_pkg::RAD_HELD && m_xzh && !abort_held && !second_seen && !qualified
      |=> state == rad_pkg::RAD_ARMED)
      else $error("hold mode did not return to waiting");
   ext_halt_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      state == rad_pkg::RAD_HELD && m_ext && abort_held |=> $stable(cnt))
      else $error("delay moved while held");
   reload_full_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      state == rad_pkg::RAD_HELD && (m_ext || m_sus) && !abort_held
      |=> state == rad_pkg::RAD_DELAY && cnt == delay_val)
      else $error("delay not reloaded");
   addon_load_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      state == rad_pkg::RAD_DELAY && m_ext && cnt_zero && !abort_held && !cap_zero
      |=> state == rad_pkg::RAD_ADDON && cnt == rad_pkg::ADDON_S)
      else $error("add-on not started");
   cap_release_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      m_ext && cap_zero && state == rad_pkg::RAD_ADDON |=> o_release)
      else $error("cap did not force release");
   release_stays_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_release |=> o_release [*2])
      else $error("release dropped");
endmodule : rad_zone_timer
`default_nettype wire

// ===== testbench/rad_field_model.sv
// Field model for one releasing zone: the detectors and the abort station.
// Assumes the bench holds i_go high for the whole of one scenario.
`timescale 1ns/1ps
`default_nettype none
module rad_field_model #(
   parameter int TK = 10
) (
   input wire logic i_sys_clk,
   input wire logic i_go,
   input wire logic [7:0] i_press_s,
   input wire logic [7:0] i_hold_s,
   input wire logic [7:0] i_second_s,
   output var logic [3:0] o_alarm = 4'h0,
   output var logic o_abort_sw = 1'b0
);
   int cyc = 0;
   int p0;
   int p1;

   // Switch window in cycles, counted from the first alarm
   assign p0 = int'(i_press_s) * TK;
   assign p1 = p0 + int'(i_hold_s) * TK;

   // Scenario clock: first alarm at once, second alarm and switch on schedule
   always @(posedge i_sys_clk)
   begin
      cyc <= i_go ? cyc + 1 : 0;
      o_alarm[0] <= i_go;
      o_alarm[1] <= i_go && (cyc >= int'(i_second_s) * TK);
      // contact bounce: a one-cycle dip just after the press
      o_abort_sw <= i_go && (cyc >= p0) && (cyc < p1) && (cyc != p0 + 1);
   end
endmodule : rad_field_model
`default_nettype wire

// ===== testbench/rad_zone_timer_tb.sv
// Self-checking bench for the zone abort delay sequencer.
// Assumes a 10-cycle second and a 2-cycle debounce to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module rad_zone_timer_tb;
   localparam int TK = 10;
   typedef struct {int ty; int dly; int cr; int pr; int hd; int sa; int ex;} rad_row_t;
   // Type, delay, cross, press, hold, second alarm, release second (255 = never)
   rad_row_t rows [10] = '{
      '{0, 3, 0, 255, 0, 255, 3}, '{0, 0, 0, 255, 0, 255, 0},
      '{0, 5, 0, 1, 2, 255, 13}, '{0, 2, 0, 1, 5, 255, 16},
      '{2, 5, 0, 2, 3, 255, 100}, '{2, 60, 0, 2, 3, 255, 125},
      '{3, 6, 0, 2, 4, 255, 12}, '{1, 3, 1, 1, 3, 2, 14},
      '{1, 2, 1, 1, 2, 5, 7}, '{1, 4, 1, 2, 2, 1, 5}};
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic go = 1'b0;
   logic [7:0] pr = 8'h00;
   logic [7:0] hd = 8'h00;
   logic [7:0] sa = 8'h00;
   logic [3:0] alarm_m;
   logic [3:0] alarm_tb = 4'h0;
   logic abort_m;
   logic [7:0] i_delay_s = 8'h00;
   logic [1:0] i_cross = 2'h0;
   logic i_type_load = 1'b0;
   logic [1:0] i_type_code = 2'h0;
   logic i_type_next = 1'b0;
   logic i_type_prev = 1'b0;
   logic [1:0] o_abort_type;
   logic [2:0] o_state;
   logic [7:0] o_seconds_left;
   logic o_release;
   int n_fail = 0;
   int samples_checked = 0;
   logic [7:0] s0;

   rad_zone_timer #(.N_DET(4), .TICK_CYCLES(TK), .DEBOUNCE_CYCLES(2)) i_rad_zone_timer (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_alarm(alarm_m | alarm_tb),
      .i_abort_sw(abort_m), .i_delay_s(i_delay_s), .i_cross(i_cross),
      .i_type_load(i_type_load), .i_type_code(i_type_code), .i_type_next(i_type_next),
      .i_type_prev(i_type_prev), .o_abort_type(o_abort_type), .o_state(o_state),
      .o_seconds_left(o_seconds_left), .o_release(o_release));

   rad_field_model #(.TK(TK)) i_rad_field_model (
      .i_sys_clk(i_sys_clk), .i_go(go), .i_press_s(pr), .i_hold_s(hd),
      .i_second_s(sa), .o_alarm(alarm_m), .o_abort_sw(abort_m));

   // 125 MHz clock
   initial
   begin
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : step

   // reset clears state and release output
   task automatic apply_reset();
      i_rst_b = 1'b0;
      step(1);
      check({5'h00, o_state}, 8'h00);
      check({7'h00, o_release}, 8'h00);
      step(9);
      i_rst_b = 1'b1;
   endtask : apply_reset

   task automatic type_op(input logic ld, input logic nx, input logic pv,
                          input logic [1:0] code, input logic [1:0] exp);
      i_type_load = ld;
      i_type_next = nx;
      i_type_prev = pv;
      i_type_code = code;
      step(1);
      i_type_load = 1'b0;
      i_type_next = 1'b0;
      i_type_prev = 1'b0;
      check({6'h00, o_abort_type}, {6'h00, exp});
   endtask : type_op

   task automatic setup(input int ty, input int dly, input int cr);
      apply_reset();
      i_delay_s = 8'(dly);
      i_cross = 2'(cr);
      type_op(1'b1, 1'b0, 1'b0, 2'(ty), 2'(ty));
   endtask : setup

   // Runs one row and measures alarm to release in cycles
   task automatic run_row(input rad_row_t r);
      int t;
      setup(r.ty, r.dly, r.cr);
      pr = 8'(r.pr);
      hd = 8'(r.hd);
      sa = 8'(r.sa);
      go = 1'b1;
      t = 0;
      while (o_release !== 1'b1 && t < 1400)
      begin
         step(1);
         t++;
      end
      check(8'((t >= r.ex * TK - TK) && (t <= r.ex * TK + 2 * TK)), 8'h01);
      go = 1'b0;
      step(20);
      check({7'h00, o_release}, 8'h01);
   endtask : run_row

   // Hang guard, well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      n_fail++;
      report_and_stop();
   end

   // Main sequence: table rows, then hand-written cases
   initial
   begin
      step(10);
      i_rst_b = 1'b1;
      check({6'h00, o_abort_type}, 8'h00);
      check(o_seconds_left, 8'h00);
      foreach (rows[k])
         run_row(rows[k]);
      // code entry and stepping with wrap
      setup(0, 3, 0);
      type_op(1'b1, 1'b0, 1'b0, 2'h2, 2'h2);
      type_op(1'b0, 1'b1, 1'b0, 2'h0, 2'h3);
      type_op(1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
      type_op(1'b0, 1'b0, 1'b1, 2'h0, 2'h3);
      type_op(1'b1, 1'b1, 1'b0, 2'h1, 2'h1);
      setup(0, 3, 0);
      alarm_tb = 4'h1;
      step(1);
      alarm_tb = 4'h0;
      step(40);
      check({5'h00, o_state}, 8'h00);
      for (int ty = 2; ty < 4; ty++)
      begin
         setup(ty, 8, 0);
         pr = 8'h02;
         hd = 8'h06;
         sa = 8'hFF;
         go = 1'b1;
         step(35);
         s0 = o_seconds_left;
         step(30);
         check(o_seconds_left, s0);
         check({7'h00, o_release}, 8'h00);
         go = 1'b0;
      end
      apply_reset();
      report_and_stop();
   end
endmodule : rad_zone_timer_tb
`default_nettype wire
